// *** hw/phjpfm_pkg.sv ***
// Constants for the port H and port J pin-function multiplexer
package phjpfm_pkg;
  localparam int          NREG       = 7;
  // Register indices; byte address is four times the index
  localparam logic [2:0]  IDX_PH     = 3'h0;
  localparam logic [2:0]  IDX_DIR    = 3'h1;
  localparam logic [2:0]  IDX_FSH    = 3'h2;
  localparam logic [2:0]  IDX_FSL    = 3'h3;
  localparam logic [2:0]  IDX_A98    = 3'h4;
  localparam logic [2:0]  IDX_A7     = 3'h5;
  localparam logic [2:0]  IDX_A30    = 3'h6;
  localparam logic [31:0] ADDR_END   = 32'h0000_001C;
  localparam logic [15:0] RST_VAL    = 16'h0000;
  // Writable bits per register, reserved bits are zero
  localparam logic [15:0] REG_MASK [NREG] = '{
    16'h0FFF, 16'h03FF, 16'h0005, 16'hD7FF,
    16'h0033, 16'h3000, 16'h3333};
  // Field positions
  localparam int J9_BIT = 2;
  localparam int J8_BIT = 0;
  localparam int J7_LSB = 14;
  localparam int J6_BIT = 12;
  localparam int J5_BIT = 10;
  localparam int J4_LSB = 8;
  localparam int J3_LSB = 6;
  localparam int J2_LSB = 4;
  localparam int J1_LSB = 2;
  localparam int J0_LSB = 0;
  localparam int A9_LSB = 4;
  localparam int A8_LSB = 0;
  localparam int A7_LSB = 12;
  localparam int A3_LSB = 12;
  localparam int A2_LSB = 8;
  localparam int A1_LSB = 4;
  localparam int A0_LSB = 0;
  // Selector codes
  localparam logic [1:0] SEL_GPIO = 2'h0;
  localparam logic [1:0] SEL_C1   = 2'h1;
  localparam logic [1:0] SEL_C2   = 2'h2;
  localparam logic [1:0] SEL_C3   = 2'h3;
  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** hw/phjpfm_top.sv ***
// Pin-function multiplexer for port H and port J with AXI4-Lite registers
// How it works
// - All registers clear on any reset kind
// - Sleep mode leaves register contents untouched
// - Reserved bits read zero, write zero
// - H pins 5-2: 00 GPIO, 11 timer
// - H pins 1,0: 10 trigger, 11 timer
// - J direction bit: 0 input, 1 output
// - Direction applies only to GPIO pins
// - J9 receive B, J8 transmit B
// - J6 receive A, J5 transmit A
// - J7: GPIO, clock B, end A, timer J1
// - J4: GPIO, clock A, end B, timer J0
// - J3: GPIO, receive A, CAN C, CAN ABC
// - J2: GPIO, transmit A, CAN C, CAN ABC
// - J1: GPIO, receive A, CAN A, CAN AB
// - J0: GPIO, transmit A, CAN A, CAN AB
// - J9 alt 11: CAN D receive
// - J8 alt 11: CAN D transmit
// - J7 alt 11: time-triggered bus enable
// - J3/J2 alt: serial B or CAN CD
// - J1/J0 alt: serial B or TT bus
// - Alt fields act only when primary 00
//
// The register offsets and the AXI4-Lite register port were decided locally.
module phjpfm_top
  import phjpfm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        hw_standby,
  input  wire logic        wdt_por,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [31:0] araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  input  wire logic [5:0]  h_pad_in,
  output logic [5:0]       h_pad_out,
  output logic [5:0]       h_pad_oe,
  input  wire logic [9:0]  j_pad_in,
  output logic [9:0]       j_pad_out,
  output logic [9:0]       j_pad_oe,
  input  wire logic [5:0]  h_gpio_out,
  input  wire logic [5:0]  h_gpio_oe,
  output logic [5:0]       h_gpio_in,
  input  wire logic [9:0]  j_gpio_out,
  output logic [9:0]       j_gpio_in,
  output logic [5:0]       timer_input_f,
  output logic             converter_trigger_a,
  output logic             converter_trigger_b,
  output logic             timer_input_j0,
  output logic             timer_input_j1,
  input  wire logic        converter_end_a,
  input  wire logic        converter_end_b,
  output logic             sci_rx_a,
  output logic             sci_rx_b,
  input  wire logic        sci_tx_a,
  input  wire logic        sci_tx_b,
  output logic             sci_clk_a_in,
  input  wire logic        sci_clk_a_out,
  input  wire logic        sci_clk_a_oe,
  output logic             sci_clk_b_in,
  input  wire logic        sci_clk_b_out,
  input  wire logic        sci_clk_b_oe,
  output logic             can_receive_chan_a,
  output logic             can_receive_chan_b,
  output logic             can_receive_chan_c,
  output logic             can_receive_chan_d,
  input  wire logic        can_transmit_chan_a,
  input  wire logic        can_transmit_chan_b,
  input  wire logic        can_transmit_chan_c,
  input  wire logic        can_transmit_chan_d,
  output logic             tt_bus_enable_a,
  output logic             tt_bus_receive_a,
  input  wire logic        tt_bus_transmit_a
);

  logic [15:0] cfg_r [NREG];
  logic        aw_got_r;
  logic        w_got_r;
  logic [31:0] waddr_r;
  logic [15:0] wdata_r;
  logic [1:0]  wstrb_r;

  // Write channel joining
  wire         aw_hs    = awvalid & awready;
  wire         w_hs     = wvalid & wready;
  wire         aw_have  = aw_got_r | aw_hs;
  wire         w_have   = w_got_r | w_hs;
  wire         wr_do    = aw_have & w_have;
  wire [31:0]  wa       = aw_hs ? awaddr : waddr_r;
  wire [15:0]  wd       = w_hs ? wdata[15:0] : wdata_r;
  wire [1:0]   ws       = w_hs ? wstrb[1:0] : wstrb_r;
  wire         wa_ok    = (wa < ADDR_END) & (wa[1:0] == 2'h0);
  wire         aw_g_nxt = aw_have & ~wr_do;
  wire         w_g_nxt  = w_have & ~wr_do;
  wire         bv_nxt   = wr_do | (bvalid & ~bready);
  wire         cfg_clr  = ~aresetn | hw_standby | wdt_por;

  // Read channel
  wire         ar_hs    = arvalid & arready;
  wire         rd_ok    = (araddr < ADDR_END) & (araddr[1:0] == 2'h0);
  wire [2:0]   rd_i     = rd_ok ? araddr[4:2] : IDX_PH;
  wire         rv_nxt   = ar_hs | (rvalid & ~rready);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r  <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
      waddr_r  <= 32'h0000_0000;
      wdata_r  <= 16'h0000;
      wstrb_r  <= 2'h0;
    end else begin
      aw_got_r <= aw_g_nxt;
      w_got_r  <= w_g_nxt;
      awready  <= ~aw_g_nxt & ~bv_nxt;
      wready   <= ~w_g_nxt & ~bv_nxt;
      bvalid   <= bv_nxt;
      if (wr_do) begin
        bresp <= wa_ok ? RESP_OKAY : RESP_SLVERR;
      end
      if (aw_hs) begin
        waddr_r <= awaddr;
      end
      if (w_hs) begin
        wdata_r <= wdata[15:0];
        wstrb_r <= wstrb[1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= ~rv_nxt;
      rvalid  <= rv_nxt;
      if (ar_hs) begin
        rdata <= rd_ok ? {16'h0000, cfg_r[rd_i]} : 32'h0000_0000;
        rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Register file; no sleep input exists, so only writes or resets alter it
  genvar g;
  for (g = 0; g < NREG; g++) begin : g_reg
    wire        hit = wr_do & wa_ok & (wa[4:2] == 3'(g));
    wire [15:0] mrg = {ws[1] ? wd[15:8] : cfg_r[g][15:8],
                       ws[0] ? wd[7:0] : cfg_r[g][7:0]};
    always_ff @(posedge aclk) begin
      if (cfg_clr) begin
        cfg_r[g] <= RST_VAL;
      end else if (hit) begin
        cfg_r[g] <= mrg & REG_MASK[g];
      end
    end
  end

  // Port H decode
  wire [5:0] h_gp;
  wire [5:0] h_tmr;
  wire [5:0] h_po_nxt;
  wire [5:0] h_pe_nxt;
  for (g = 0; g < 6; g++) begin : g_h
    wire [1:0] sel = cfg_r[IDX_PH][2*g +: 2];
    assign h_gp[g]     = (sel == SEL_GPIO);
    assign h_tmr[g]    = (sel == SEL_C3) & h_pad_in[g];
    assign h_po_nxt[g] = h_gp[g] & h_gpio_out[g];
    assign h_pe_nxt[g] = h_gp[g] & h_gpio_oe[g];
  end
  wire trg_a = (cfg_r[IDX_PH][1:0] == SEL_C2) & h_pad_in[0];
  wire trg_b = (cfg_r[IDX_PH][3:2] == SEL_C2) & h_pad_in[1];

  // Port J primary and effective alternate selections
  wire [15:0] fsl = cfg_r[IDX_FSL];
  wire        p9  = cfg_r[IDX_FSH][J9_BIT];
  wire        p8  = cfg_r[IDX_FSH][J8_BIT];
  wire [1:0]  s7  = fsl[J7_LSB +: 2];
  wire        p6  = fsl[J6_BIT];
  wire        p5  = fsl[J5_BIT];
  wire [1:0]  s4  = fsl[J4_LSB +: 2];
  wire [1:0]  s3  = fsl[J3_LSB +: 2];
  wire [1:0]  s2  = fsl[J2_LSB +: 2];
  wire [1:0]  s1  = fsl[J1_LSB +: 2];
  wire [1:0]  s0  = fsl[J0_LSB +: 2];
  wire a9 = ~p9 & (cfg_r[IDX_A98][A9_LSB +: 2] == SEL_C3);
  wire a8 = ~p8 & (cfg_r[IDX_A98][A8_LSB +: 2] == SEL_C3);
  wire a7 = (s7 == SEL_GPIO) &
            (cfg_r[IDX_A7][A7_LSB +: 2] == SEL_C3);
  wire [1:0] t3 = (s3 == SEL_GPIO) ? cfg_r[IDX_A30][A3_LSB +: 2]
                                   : SEL_GPIO;
  wire [1:0] t2 = (s2 == SEL_GPIO) ? cfg_r[IDX_A30][A2_LSB +: 2]
                                   : SEL_GPIO;
  wire [1:0] t1 = (s1 == SEL_GPIO) ? cfg_r[IDX_A30][A1_LSB +: 2]
                                   : SEL_GPIO;
  wire [1:0] t0 = (s0 == SEL_GPIO) ? cfg_r[IDX_A30][A0_LSB +: 2]
                                   : SEL_GPIO;
  wire t3b = t3[1];
  wire t2b = t2[1];
  wire t1b = t1[1];
  wire t0b = t0[1];

  // Per-pin GPIO flag; prohibited alt code 01 leaves the pin as GPIO
  wire [9:0] j_gp = {~p9 & ~a9, ~p8 & ~a8, (s7 == SEL_GPIO) & ~a7,
                     ~p6, ~p5, s4 == SEL_GPIO,
                     (s3 == SEL_GPIO) & ~t3b, (s2 == SEL_GPIO) & ~t2b,
                     (s1 == SEL_GPIO) & ~t1b, (s0 == SEL_GPIO) & ~t0b};

  // Peripheral drive of pins 8, 7, 5, 4, 2 and 0
  wire o8 = p8 ? sci_tx_b : can_transmit_chan_d;
  wire o7 = a7 ? 1'b1 /* enable asserted */ :
            (s7 == SEL_C1) ? sci_clk_b_out : converter_end_a;
  wire e7 = a7 | (s7 == SEL_C2) |
            ((s7 == SEL_C1) & sci_clk_b_oe);
  wire o4 = (s4 == SEL_C1) ? sci_clk_a_out : converter_end_b;
  wire e4 = (s4 == SEL_C2) | ((s4 == SEL_C1) & sci_clk_a_oe);
  wire can_abc = can_transmit_chan_a & can_transmit_chan_b &
                 can_transmit_chan_c;
  wire can_ab  = can_transmit_chan_a & can_transmit_chan_b;
  wire can_cd  = can_transmit_chan_c & can_transmit_chan_d;
  wire o2 = t2b ? (t2[0] ? can_cd : sci_tx_b) :
            (s2 == SEL_C1) ? sci_tx_a :
            (s2 == SEL_C2) ? can_transmit_chan_c : can_abc;
  wire o0 = t0b ? (t0[0] ? tt_bus_transmit_a : sci_tx_b) :
            (s0 == SEL_C1) ? sci_tx_a :
            (s0 == SEL_C2) ? can_transmit_chan_a : can_ab;

  wire [9:0] j_po = {1'b0, o8, o7, 1'b0, sci_tx_a, o4,
                     1'b0, o2, 1'b0, o0};
  wire [9:0] j_pe = {1'b0, 1'b1, e7, 1'b0, 1'b1, e4,
                     1'b0, 1'b1, 1'b0, 1'b1};
  wire [9:0] j_po_nxt;
  wire [9:0] j_pe_nxt;
  for (g = 0; g < 10; g++) begin : g_j
    assign j_po_nxt[g] = j_gp[g] ? j_gpio_out[g] : j_po[g];
    assign j_pe_nxt[g] = j_gp[g] ? cfg_r[IDX_DIR][g]
                                 : j_pe[g];
  end

  // Pin levels toward the peripherals; idle levels when not routed
  wire rxa_nxt = p6 ? j_pad_in[6] :
                 (s3 == SEL_C1) ? j_pad_in[3] :
                 (s1 == SEL_C1) ? j_pad_in[1] : 1'b1;
  wire rxb_nxt = p9 ? j_pad_in[9] :
                 (t3 == SEL_C2) ? j_pad_in[3] :
                 (t1 == SEL_C2) ? j_pad_in[1] : 1'b1;
  wire cra_nxt = s1[1] ? j_pad_in[1] :
                 (s3 == SEL_C3) ? j_pad_in[3] : 1'b1;
  wire crb_nxt = (s1 == SEL_C3) ? j_pad_in[1] :
                 (s3 == SEL_C3) ? j_pad_in[3] : 1'b1;
  wire crc_nxt = (s3[1] | (t3 == SEL_C3)) ? j_pad_in[3] : 1'b1;
  wire crd_nxt = a9 ? j_pad_in[9] :
                 (t3 == SEL_C3) ? j_pad_in[3] : 1'b1;
  wire tr_nxt  = (t1 == SEL_C3) ? j_pad_in[1] : 1'b1;
  wire tj0_nxt = (s4 == SEL_C3) & j_pad_in[4];
  wire tj1_nxt = (s7 == SEL_C3) & j_pad_in[7];
  wire cka_nxt = (s4 == SEL_C1) & j_pad_in[4];
  wire ckb_nxt = (s7 == SEL_C1) & j_pad_in[7];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_pad_out           <= 6'h00;
      h_pad_oe            <= 6'h00;
      j_pad_out           <= 10'h000;
      j_pad_oe            <= 10'h000;
      h_gpio_in           <= 6'h00;
      j_gpio_in           <= 10'h000;
      timer_input_f       <= 6'h00;
      converter_trigger_a <= 1'b0;
      converter_trigger_b <= 1'b0;
      timer_input_j0      <= 1'b0;
      timer_input_j1      <= 1'b0;
      sci_clk_a_in        <= 1'b0;
      sci_clk_b_in        <= 1'b0;
      sci_rx_a            <= 1'b1;
      sci_rx_b            <= 1'b1;
      can_receive_chan_a  <= 1'b1;
      can_receive_chan_b  <= 1'b1;
      can_receive_chan_c  <= 1'b1;
      can_receive_chan_d  <= 1'b1;
      tt_bus_enable_a     <= 1'b0;
      tt_bus_receive_a    <= 1'b1;
    end else begin
      h_pad_out           <= h_po_nxt;
      h_pad_oe            <= h_pe_nxt;
      j_pad_out           <= j_po_nxt;
      j_pad_oe            <= j_pe_nxt;
      h_gpio_in           <= h_pad_in;
      j_gpio_in           <= j_pad_in;
      timer_input_f       <= h_tmr;
      converter_trigger_a <= trg_a;
      converter_trigger_b <= trg_b;
      timer_input_j0      <= tj0_nxt;
      timer_input_j1      <= tj1_nxt;
      sci_clk_a_in        <= cka_nxt;
      sci_clk_b_in        <= ckb_nxt;
      sci_rx_a            <= rxa_nxt;
      sci_rx_b            <= rxb_nxt;
      can_receive_chan_a  <= cra_nxt;
      can_receive_chan_b  <= crb_nxt;
      can_receive_chan_c  <= crc_nxt;
      can_receive_chan_d  <= crd_nxt;
      tt_bus_enable_a     <= a7;
      tt_bus_receive_a    <= tr_nxt;
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  cfg_clear_a: assert property (
    (hw_standby | wdt_por) |=> (cfg_r[IDX_PH] == RST_VAL) &&
      (cfg_r[IDX_FSL] == RST_VAL) && (cfg_r[IDX_A30] == RST_VAL))
    else $error("Registers not cleared by standby or watchdog reset");

  cfg_hold_a: assert property (
    (!wr_do && !hw_standby && !wdt_por) |=>
      $stable(cfg_r[IDX_FSL]) && $stable(cfg_r[IDX_DIR]))
    else $error("Register changed without a write");

  read_rsvd_a: assert property (
    ar_hs && rd_ok && (araddr[4:2] == IDX_FSH) |=>
      rvalid && (rdata[31:3] == 29'h0) && !rdata[1])
    else $error("Reserved bits read nonzero");

  write_next_a: assert property (
    wr_do && wa_ok && (wa[4:2] == IDX_PH) && (ws == 2'h3) |=>
      cfg_r[IDX_PH] == ($past(wd) & REG_MASK[IDX_PH]))
    else $error("Write not applied at next edge");

  h_timer_a: assert property (
    (cfg_r[IDX_PH][11:10] == SEL_C3) |=>
      (timer_input_f[5] == $past(h_pad_in[5])) && !h_pad_oe[5])
    else $error("H pin 5 timer routing wrong");

  h_trigger_a: assert property (
    (cfg_r[IDX_PH][3:2] == SEL_C2) |=>
      (converter_trigger_b == $past(h_pad_in[1])) && !timer_input_f[1])
    else $error("H pin 1 trigger routing wrong");

  j_dir_a: assert property (
    j_gp[5] |=> j_pad_oe[5] == $past(cfg_r[IDX_DIR][5]))
    else $error("J pin 5 direction wrong");

  j_alt_block_a: assert property (
    (s3 != SEL_GPIO) |=> (sci_rx_b == 1'b1 || $past(p9) ||
      $past(t1 == SEL_C2)) && (can_receive_chan_d || $past(a9)))
    else $error("Alternate field acted despite primary selection");

  j_tx_a: assert property (
    (s2 == SEL_C1) |=> j_pad_oe[2] && (j_pad_out[2] == $past(sci_tx_a)))
    else $error("J pin 2 transmit routing wrong");

  write_resp_a: assert property (
    wr_do |=> bvalid && !awready && !wready)
    else $error("Write response missing");

endmodule

// *** bench/phjpfm_peri_model.sv ***
// Model of the on-chip peripherals facing the multiplexer's inner side
module phjpfm_peri_model
  import phjpfm_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic [12:0] pat,
  output logic             sci_tx_a,
  output logic             sci_tx_b,
  output logic             sci_clk_a_out,
  output logic             sci_clk_a_oe,
  output logic             sci_clk_b_out,
  output logic             sci_clk_b_oe,
  output logic             can_transmit_chan_a,
  output logic             can_transmit_chan_b,
  output logic             can_transmit_chan_c,
  output logic             can_transmit_chan_d,
  output logic             converter_end_a,
  output logic             converter_end_b,
  output logic             tt_bus_transmit_a
);
  // Each peripheral offers its own pin value; only the serial clocks also offer an enable
  always_ff @(posedge aclk) begin
    {sci_tx_a, sci_tx_b, sci_clk_a_out, sci_clk_a_oe, sci_clk_b_out,
     sci_clk_b_oe, can_transmit_chan_a, can_transmit_chan_b,
     can_transmit_chan_c, can_transmit_chan_d, converter_end_a,
     converter_end_b, tt_bus_transmit_a} <= pat;
  end
endmodule

// *** bench/phjpfm_tb_top.sv ***
// Self-checking testbench of the port H and port J pin multiplexer
module phjpfm_tb_top
  import phjpfm_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, hw_standby, wdt_por, awvalid, awready, wvalid;
  logic wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [5:0] h_pad_in, h_pad_out, h_pad_oe, h_gpio_out, h_gpio_oe;
  logic [5:0] h_gpio_in, timer_input_f;
  logic [9:0] j_pad_in, j_pad_out, j_pad_oe, j_gpio_out, j_gpio_in;
  logic converter_trigger_a, converter_trigger_b, timer_input_j0;
  logic timer_input_j1, converter_end_a, converter_end_b, sci_rx_a;
  logic sci_rx_b, sci_tx_a, sci_tx_b, sci_clk_a_in, sci_clk_a_out;
  logic sci_clk_a_oe, sci_clk_b_in, sci_clk_b_out, sci_clk_b_oe;
  logic can_receive_chan_a, can_receive_chan_b, can_receive_chan_c;
  logic can_receive_chan_d, can_transmit_chan_a, can_transmit_chan_b;
  logic can_transmit_chan_c, can_transmit_chan_d, tt_bus_enable_a;
  logic tt_bus_receive_a, tt_bus_transmit_a;
  logic [12:0] pat;
  logic [31:0] rd_v;
  logic [1:0]  rd_r;
  int n_errors, checked, cyc;

  phjpfm_top        u_dut  (.*);
  phjpfm_peri_model u_peri (.*);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  function automatic logic [31:0] adr(input logic [2:0] i);
    return {27'h000_0000, i, 2'h0};
  endfunction

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic results();
    if (n_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      results();
    end
  end

  task automatic wr(input logic [31:0] a, input logic [31:0] d,
                    input logic [1:0] er);
    logic pa, pw, ta, tw;
    pa = 1'b1;
    pw = 1'b1;
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    awaddr  <= a;
    wdata   <= d;
    bready  <= 1'b1;
    while (pa || pw) begin
      @(negedge aclk);
      ta = pa && awready;
      tw = pw && wready;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      pa = pa && !ta;
      pw = pw && !tw;
    end
    do @(negedge aclk); while (bvalid !== 1'b1);
    chk(bresp, er);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [31:0] a);
    @(posedge aclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(negedge aclk); while (arready !== 1'b1);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (rvalid !== 1'b1);
    rd_v = rdata;
    rd_r = rresp;
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic settle();
    repeat (4) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic t_reset_map();
    for (int i = 0; i < NREG; i++) begin
      rd(adr(3'(i)));
      chk(rd_v, 32'h0000_0000);
    end
    @(negedge aclk);
    chk({sci_rx_a, sci_rx_b, can_receive_chan_a, can_receive_chan_b,
         can_receive_chan_c, can_receive_chan_d, tt_bus_receive_a,
         tt_bus_enable_a}, 8'hFE);
    rd(ADDR_END);
    chk(rd_v, 32'h0000_0000);
    chk(rd_r, RESP_SLVERR);
    wr(ADDR_END, 32'hFFFF_FFFF, RESP_SLVERR);
  endtask

  task automatic t_masks_clear();
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < NREG; i++) begin
        wr(adr(3'(i)), {16'h0000, REG_MASK[i]}, RESP_OKAY);
        rd(adr(3'(i)));
        chk(rd_v, {16'h0000, REG_MASK[i]});
      end
      repeat (20) @(posedge aclk);
      rd(adr(IDX_FSL));
      chk(rd_v, {16'h0000, REG_MASK[3]});
      @(posedge aclk);
      if (k == 0) hw_standby <= 1'b1;
      else wdt_por <= 1'b1;
      @(posedge aclk);
      hw_standby <= 1'b0;
      wdt_por    <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
        rd(adr(3'(i)));
        chk(rd_v, 32'h0000_0000);
      end
    end
  endtask

  task automatic t_hport();
    wr(adr(IDX_PH), 32'h0000_0FFF, RESP_OKAY);
    h_pad_in <= 6'h2A;
    settle();
    chk(timer_input_f, 6'h2A);
    chk(h_pad_oe, 6'h00);
    wr(adr(IDX_PH), 32'h0000_000A, RESP_OKAY);
    h_pad_in <= 6'h03;
    settle();
    chk({converter_trigger_b, converter_trigger_a}, 2'h3);
    chk(timer_input_f, 6'h00);
    wr(adr(IDX_PH), 32'h0000_0000, RESP_OKAY);
    h_gpio_oe  <= 6'h3F;
    h_gpio_out <= 6'h15;
    settle();
    chk({h_pad_oe, h_pad_out}, {6'h3F, 6'h15});
  endtask

  task automatic t_jport();
    wr(adr(IDX_DIR), 32'h0000_03FF, RESP_OKAY);
    j_gpio_out <= 10'h155;
    j_pad_in   <= 10'h2AA;
    settle();
    chk({j_pad_oe, j_pad_out}, {10'h3FF, 10'h155});
    chk(j_gpio_in, 10'h2AA);
    wr(adr(IDX_FSL), 32'h0000_C000, RESP_OKAY);
    settle();
    chk({j_pad_oe[7], timer_input_j1}, 2'h1);
    wr(adr(IDX_FSL), 32'h0000_8000, RESP_OKAY);
    pat <= 13'h0004;
    settle();
    chk({j_pad_oe[7], j_pad_out[7]}, 2'h3);
    wr(adr(IDX_FSL), 32'h0000_0001, RESP_OKAY);
    wr(adr(IDX_A30), 32'h0000_0003, RESP_OKAY);
    pat <= 13'h0001;
    settle();
    chk(j_pad_out[0], 1'b0);
    wr(adr(IDX_FSL), 32'h0000_0000, RESP_OKAY);
    settle();
    chk(j_pad_out[0], 1'b1);
    wr(adr(IDX_FSH), 32'h0000_0001, RESP_OKAY);
    wr(adr(IDX_A98), 32'h0000_0033, RESP_OKAY);
    pat <= 13'h0008;
    settle();
    chk(j_pad_out[8], 1'b0);
    wr(adr(IDX_FSH), 32'h0000_0000, RESP_OKAY);
    j_pad_in <= 10'h000;
    settle();
    chk({j_pad_out[8], can_receive_chan_d}, 2'h2);
  endtask

  // Further primary and alternate codes of port J pins 7, 6 and 4 to 0
  task automatic t_jroute();
    wr(adr(IDX_A98), 32'h0000_0000, RESP_OKAY);
    wr(adr(IDX_A30), 32'h0000_0000, RESP_OKAY);
    wr(adr(IDX_FSL), 32'h0000_016B, RESP_OKAY);
    j_pad_in <= 10'h010;
    pat      <= 13'h0040;
    settle();
    chk({j_pad_oe[4], j_pad_out[4], j_pad_oe[3], j_pad_oe[1]},
        4'h0);
    chk({j_pad_oe[2], j_pad_out[2], j_pad_oe[0], j_pad_out[0]},
        4'hA);
    chk({sci_rx_a, can_receive_chan_a, can_receive_chan_b,
         can_receive_chan_c}, 4'h3);
    chk({sci_clk_a_in, timer_input_j0}, 2'h2);
    wr(adr(IDX_FSL), 32'h0000_43DD, RESP_OKAY);
    j_pad_in <= 10'h098;
    pat      <= 13'h0180;
    settle();
    chk({timer_input_j0, sci_clk_a_in, sci_clk_b_in, timer_input_j1},
        4'hA);
    chk({can_receive_chan_a, can_receive_chan_b, can_receive_chan_c,
         sci_rx_a}, 4'h3);
    chk({j_pad_oe[7], j_pad_out[7], j_pad_out[2], j_pad_out[0]},
        4'hC);
    wr(adr(IDX_FSL), 32'h0000_0000, RESP_OKAY);
    wr(adr(IDX_A7), 32'h0000_3000, RESP_OKAY);
    wr(adr(IDX_A30), 32'h0000_2332, RESP_OKAY);
    j_pad_in <= 10'h000;
    pat      <= 13'h0010;
    settle();
    chk({sci_rx_b, tt_bus_receive_a, can_receive_chan_c,
         can_receive_chan_d}, 4'h3);
    chk({tt_bus_enable_a, j_pad_oe[7], j_pad_out[7]}, 3'h7);
    chk({j_pad_oe[2], j_pad_out[2], j_pad_oe[0], j_pad_out[0]},
        4'hA);
    chk({j_pad_oe[3], j_pad_oe[1]}, 2'h0);
    wr(adr(IDX_FSL), 32'h0000_9200, RESP_OKAY);
    wr(adr(IDX_A30), 32'h0000_3223, RESP_OKAY);
    pat <= 13'h0002;
    settle();
    chk({sci_rx_b, tt_bus_receive_a, can_receive_chan_c,
         can_receive_chan_d}, 4'h4);
    chk({tt_bus_enable_a, j_pad_oe[7], j_pad_out[7]},
        3'h2);
    chk({sci_rx_a, j_pad_oe[6], j_pad_out[2], j_pad_out[0]},
        4'h0);
    chk({j_pad_oe[4], j_pad_out[4]}, 2'h3);
  endtask

  initial begin
    {aresetn, hw_standby, wdt_por, awvalid, wvalid, bready} = '0;
    {arvalid, rready} = '0;
    {awaddr, wdata, araddr} = '0;
    wstrb = 4'hF;
    {h_pad_in, h_gpio_out, h_gpio_oe} = '0;
    {j_pad_in, j_gpio_out} = '0;
    pat = 13'h0000;
    n_errors = 0;
    checked = 0;
    cyc = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset_map();
    t_masks_clear();
    t_hport();
    t_jport();
    t_jroute();
    results();
  end
endmodule
